// *** ppnvm_pkg.sv ***
package ppnvm_pkg;

  // ****************************************
  // Action select codes
  // ****************************************
  localparam logic [1:0] ACT_ADDR = 2'b00;
  localparam logic [1:0] ACT_DATA = 2'b01;
  localparam logic [1:0] ACT_CMD  = 2'b10;
  localparam logic [1:0] ACT_IDLE = 2'b11;

  // ****************************************
  // Command bytes
  // ****************************************
  localparam logic [7:0] CMD_NOP       = 8'h00;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK   = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_ID     = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE   = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

  // ****************************************
  // Memory geometry
  // ****************************************
  localparam int FLASH_WORDS = 1024;
  localparam int FLASH_AW    = 10;
  localparam int FPAGE_WORDS = 16;
  localparam int FPAGE_AW    = 4;
  localparam int EE_BYTES    = 128;
  localparam int EE_AW       = 7;
  localparam int EPAGE_BYTES = 4;
  localparam int EPAGE_AW    = 2;
  localparam int ID_BYTES    = 3;
  localparam int CAL_BYTES   = 4;

  // ****************************************
  // Reset values and fuse positions
  // ****************************************
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  localparam logic [15:0] ERASED_WORD    = 16'hffff;
  localparam logic [7:0]  FUSE_LO_RST    = 8'hff;
  localparam logic [7:0]  FUSE_HI_RST    = 8'hff;
  localparam int          KEEP_EE_BIT    = 3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ      = 250;
  localparam int PROG_TIME_US = 3700;
  localparam int ERASE_TIME_US = 7500;
  localparam int PROG_CYC     = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC    = ERASE_TIME_US * CLK_MHZ;
  localparam int BUSY_W       = 22;

  typedef enum logic [1:0] {
    PP_IDLE  = 2'b00,
    PP_BUSY  = 2'b01,
    PP_ERASE = 2'b10,
    PP_LOCK  = 2'b11
  } ppnvm_state_t;

endpackage : ppnvm_pkg

// *** ppnvm_port.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Command and address persist across operations
// - Erase-all clears flash, lock, and EEPROM unless fuse-high KEEP_EE_BIT is 0; fuses kept
// - Lock bits cleared after flash erase
// - Command load: action 10, strobe pulse
// - Write strobe starts operation; busy low
// - Command 0001 0000 writes flash
// - Action 00 loads address byte
// - Action 01 loads data byte, low first
// - Flash words collected in page buffer
// - Low bits word, high bits page
// - Write strobe programs the loaded words of the flash page
// - No-op command resets write signals
// - EEPROM page write command 0001 0001
// - Flash read: low/high byte by select
// - EEPROM read drives addressed byte
// - Fuse write: zero programs, select picks byte
// - Lock write; only erase-all clears locks
// - Fuse/lock read selected by byte selects
// - Identification read for address 0..2
// - Select one high reads calibration byte
// - Idle action and no strobe: latches hold
// - Ready/busy low while operation runs
// - Data bus driven only while output enable low
module ppnvm_port
  import ppnvm_pkg::*;
#(
  parameter int PROG_CYCLES  = PROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter logic [7:0] ID_BYTE0 = 8'h5a,  // Arbitrary identity value
  parameter logic [7:0] ID_BYTE1 = 8'h12,  // Arbitrary identity value
  parameter logic [7:0] ID_BYTE2 = 8'h34,  // Arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80
)(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Programmer control pins
  input  wire logic       load_strobe_i,
  input  wire logic       action_select_hi_i,
  input  wire logic       action_select_lo_i,
  input  wire logic       byte_select_one_i,
  input  wire logic       byte_select_two_i,
  input  wire logic       write_n_i,
  input  wire logic       output_enable_n_i,
  // Data bus
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  // Status
  output logic            ready_busy_flag_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [13:0] sync1_r;
  logic [13:0] sync2_r;
  logic        load_sync1_r;
  logic        load_sync2_r;
  logic        strobe_d_r;
  logic        wr_d_r;

  wire       load_q  = load_sync2_r;
  wire [1:0] act_q   = sync2_r[1:0];
  wire       bs1_q   = sync2_r[2];
  wire       bs2_q   = sync2_r[3];
  wire       wr_q    = sync2_r[4];
  wire       oe_n_q  = sync2_r[5];
  wire [7:0] din_q   = sync2_r[13:6];

  // Strobe, action, write and enable reset to their idle levels, so no false edge follows reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      sync1_r    <= 14'h3fff;
      sync2_r    <= 14'h3fff;
      strobe_d_r <= 1'b0;
      wr_d_r     <= 1'b1;
    end
    else
    begin
      sync1_r    <= {data_i, output_enable_n_i, write_n_i, byte_select_two_i,
                     byte_select_one_i, action_select_hi_i, action_select_lo_i};
      sync2_r    <= sync1_r;
      strobe_d_r <= load_q;
      wr_d_r     <= wr_q;
    end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      load_sync1_r <= 1'b0;
      load_sync2_r <= 1'b0;
    end
    else
    begin
      load_sync1_r <= load_strobe_i;
      load_sync2_r <= load_sync1_r;
    end

  // Rising edge captures the settled controls
  wire load_rise = load_q & ~strobe_d_r;
  wire wr_fall   = ~wr_q & wr_d_r;

  // ****************************************
  // Command, address and data latches
  // ****************************************
  logic [7:0]  cmd_r;
  logic [7:0]  addr_lo_r;
  logic [7:0]  addr_hi_r;
  logic [7:0]  dat_lo_r;
  logic        wr_arm_r;
  ppnvm_state_t state_r;
  wire busy = (state_r != PP_IDLE);

  wire ld_cmd  = load_rise && act_q == ACT_CMD && !busy;
  wire ld_addr = load_rise && act_q == ACT_ADDR;
  wire ld_data = load_rise && act_q == ACT_DATA;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      cmd_r     <= CMD_NOP;
      addr_lo_r <= 8'h00;
      addr_hi_r <= 8'h00;
      dat_lo_r  <= 8'hff;
      wr_arm_r  <= 1'b0;
    end
    else
    begin
      // Latches only move on a strobe; idle code holds everything
      if (ld_cmd)
      begin
        cmd_r    <= din_q;
        wr_arm_r <= (din_q != CMD_NOP);
      end
      if (ld_addr && !bs1_q)
        addr_lo_r <= din_q;
      if (ld_addr && bs1_q)
        addr_hi_r <= din_q;
      if (ld_data && !bs1_q)
        dat_lo_r <= din_q;
    end

  // ****************************************
  // Storage
  // ****************************************
  logic [15:0] flash_r [FLASH_WORDS];
  logic [7:0]  ee_r    [EE_BYTES];
  logic [15:0] fbuf_r  [FPAGE_WORDS];
  logic [7:0]  ebuf_r  [EPAGE_BYTES];
  logic [FPAGE_WORDS-1:0] fbuf_v_r;
  logic [EPAGE_BYTES-1:0] ebuf_v_r;
  logic [7:0]  fuse_lo_r;
  logic [7:0]  fuse_hi_r;
  logic [7:0]  lock_r;
  logic [BUSY_W-1:0] cnt_r;
  logic [7:0]  dout_r;
  logic        oe_r;
  logic        rdy_r;

  wire [FLASH_AW-1:0] faddr = {addr_hi_r[1:0], addr_lo_r};
  wire [FPAGE_AW-1:0] fword = addr_lo_r[FPAGE_AW-1:0];
  wire [FLASH_AW-FPAGE_AW-1:0] fpage = faddr[FLASH_AW-1:FPAGE_AW];
  wire [EE_AW-1:0]    eaddr = addr_lo_r[EE_AW-1:0];
  wire [EPAGE_AW-1:0] eword = eaddr[EPAGE_AW-1:0];
  wire [EE_AW-EPAGE_AW-1:0] epage = eaddr[EE_AW-1:EPAGE_AW];
  wire keep_ee = ~fuse_hi_r[KEEP_EE_BIT];

  wire start     = wr_fall && !busy && wr_arm_r;
  wire go_erase  = start && cmd_r == CMD_ERASE_ALL;
  wire go_flash  = start && cmd_r == CMD_WR_FLASH && !bs1_q;
  wire go_ee     = start && cmd_r == CMD_WR_EEPROM && !bs1_q;
  wire go_fuse   = start && cmd_r == CMD_WR_FUSE && !bs2_q;
  wire go_lock   = start && cmd_r == CMD_WR_LOCK;
  wire go_any    = go_erase | go_flash | go_ee | go_fuse | go_lock;
  wire cnt_done  = (cnt_r == 22'h0);

  // Page writes commit at the start; busy time models the cell delay
  always_ff @(posedge clk_sys_i)
  begin
    if (ld_data && !bs1_q && cmd_r == CMD_WR_EEPROM)
      ebuf_r[eword] <= din_q;
    if (ld_data && bs1_q && cmd_r == CMD_WR_FLASH)
      fbuf_r[fword] <= {din_q, dat_lo_r};
    for (int i = 0; i < FPAGE_WORDS; i++)
      if (go_flash && fbuf_v_r[i])
        flash_r[{fpage, FPAGE_AW'(i)}] <= fbuf_r[i] & flash_r[{fpage, FPAGE_AW'(i)}];
    for (int i = 0; i < EPAGE_BYTES; i++)
      if (go_ee && ebuf_v_r[i])
        ee_r[{epage, EPAGE_AW'(i)}] <= ebuf_r[i];
    if (state_r == PP_ERASE && cnt_done)
    begin
      for (int i = 0; i < FLASH_WORDS; i++)
        flash_r[i] <= ERASED_WORD;
      if (!keep_ee)
        for (int i = 0; i < EE_BYTES; i++)
          ee_r[i] <= ERASED_BYTE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      fbuf_v_r  <= '0;
      ebuf_v_r  <= '0;
      fuse_lo_r <= FUSE_LO_RST;
      fuse_hi_r <= FUSE_HI_RST;
      lock_r    <= 8'hff;
      cnt_r     <= 22'h0;
      state_r   <= PP_IDLE;
    end
    else
    begin
      if (go_flash || (ld_cmd && din_q == CMD_NOP))
        fbuf_v_r <= '0;
      if (go_ee || (ld_cmd && din_q == CMD_NOP))
        ebuf_v_r <= '0;
      // Set after clear: a load landing with the commit is kept
      if (ld_data && bs1_q && cmd_r == CMD_WR_FLASH)
        fbuf_v_r[fword] <= 1'b1;
      if (ld_data && !bs1_q && cmd_r == CMD_WR_EEPROM)
        ebuf_v_r[eword] <= 1'b1;
      if (go_fuse && !bs1_q)
        fuse_lo_r <= dat_lo_r;
      if (go_fuse && bs1_q)
        fuse_hi_r <= dat_lo_r;
      if (go_lock)
        lock_r <= lock_r & dat_lo_r;
      case (state_r)
        PP_IDLE:
          if (go_any)
          begin
            state_r <= go_erase ? PP_ERASE : PP_BUSY;
            cnt_r   <= go_erase ? 22'(ERASE_CYCLES - 1) : 22'(PROG_CYCLES - 1);
          end
        PP_BUSY:
          if (cnt_done)
            state_r <= PP_IDLE;
          else
            cnt_r <= cnt_r - 22'h1;
        PP_ERASE:
          if (cnt_done)
            state_r <= PP_LOCK;
          else
            cnt_r <= cnt_r - 22'h1;
        PP_LOCK:
        begin
          lock_r  <= 8'hff;
          state_r <= PP_IDLE;
        end
        default:
          state_r <= PP_IDLE;
      endcase
    end

  // ****************************************
  // Read path
  // ****************************************
  wire [15:0] fword_rd = flash_r[faddr];
  wire [7:0]  id_rd    = addr_lo_r == 8'h00 ? ID_BYTE0 :
                         addr_lo_r == 8'h01 ? ID_BYTE1 :
                         addr_lo_r == 8'h02 ? ID_BYTE2 : 8'hff;
  wire [7:0]  cal_rd   = (addr_lo_r < 8'(CAL_BYTES)) ? CAL_BYTE : 8'hff;
  wire [7:0]  fl_rd    = !bs1_q ? (bs2_q ? 8'hff : fuse_lo_r) :
                         (bs2_q ? fuse_hi_r : lock_r);
  wire [7:0]  rd_mux   =
    cmd_r == CMD_RD_FLASH  ? (bs1_q ? fword_rd[15:8] : fword_rd[7:0]) :
    cmd_r == CMD_RD_EEPROM ? ee_r[eaddr] :
    cmd_r == CMD_RD_FUSE   ? fl_rd :
    cmd_r == CMD_RD_ID     ? (bs1_q ? cal_rd : id_rd) : 8'hff;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      dout_r <= 8'h00;
      oe_r   <= 1'b0;
      rdy_r  <= 1'b1;
    end
    else
    begin
      dout_r <= rd_mux;
      oe_r   <= ~oe_n_q;
      rdy_r  <= ~(busy | go_any);
    end

  assign data_o            = dout_r;
  assign data_oe_o         = oe_r;
  assign ready_busy_flag_o = rdy_r;

  // ****************************************
  // Checks
  // ****************************************
  a_busy_on_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    go_any |=> !ready_busy_flag_o)
    else $error("ready stayed high after start");
  a_ready_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_r == PP_IDLE) && !go_any |=> ready_busy_flag_o)
    else $error("ready low while idle");
  a_oe_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    oe_n_q |=> !data_oe_o)
    else $error("bus driven without output enable");
  a_cmd_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !load_rise |=> $stable(cmd_r) && $stable(addr_lo_r))
    else $error("latch moved without strobe");
  a_lock_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_r != PP_LOCK |=> !$rose(lock_r[0]))
    else $error("lock bit cleared outside erase");
  a_erase_order: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_r == PP_ERASE && cnt_done |=> state_r == PP_LOCK ##1 lock_r == 8'hff)
    else $error("lock clear out of order");
  a_fuse_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    go_fuse && !bs1_q |=> fuse_lo_r == $past(dat_lo_r))
    else $error("low fuse not written");
  a_nop_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ld_cmd && din_q == CMD_NOP |=> !wr_arm_r && fbuf_v_r == '0)
    else $error("write signals not reset");

endmodule : ppnvm_port

// *** ppnvm_prog_model.sv ***
`timescale 1ns/1ps
module ppnvm_prog_model
  import ppnvm_pkg::*;
(
  // Device side
  input  wire logic       clk_sys_i,
  input  wire logic       ready_i,
  input  wire logic [7:0] bus_i,
  // Programmer pins
  output logic            strobe_o,
  output logic [1:0]      act_o,
  output logic            bs1_o,
  output logic            bs2_o,
  output logic            wr_n_o,
  output logic            oe_n_o,
  output logic            drv_o,
  output logic [7:0]      dat_o
);
  initial
  begin
    {strobe_o, bs1_o, bs2_o} = 3'h0;
    {wr_n_o, oe_n_o, drv_o} = 3'h7;
    act_o = ACT_IDLE;
    dat_o = 8'h00;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : ticks

  // Controls steady 4 cycles around the strobe to cover the 2-FF sync
  task automatic pulse(input logic [1:0] act, input logic b1, input logic [7:0] d);
    act_o <= act;
    bs1_o <= b1;
    bs2_o <= 1'b0;
    dat_o <= d;
    ticks(4);
    strobe_o <= 1'b1;
    ticks(4);
    strobe_o <= 1'b0;
    ticks(4);
  endtask : pulse

  task automatic cmd(input logic [7:0] c);
    int n;
    n = 0;
    while (ready_i !== 1'b1 && n < 400)
    begin
      ticks(1);
      n++;
    end
    pulse(ACT_CMD, 1'b0, c);
  endtask : cmd

  task automatic wr(input logic b1, input logic b2, output logic busy, output logic done);
    int n;
    bs1_o <= b1;
    bs2_o <= b2;
    ticks(4);
    wr_n_o <= 1'b0;
    ticks(4);
    wr_n_o <= 1'b1;
    busy = 1'b0;
    for (n = 0; n < 8; n++)
    begin
      ticks(1);
      if (ready_i === 1'b0)
        busy = 1'b1;
    end
    n = 0;
    while (ready_i !== 1'b1 && n < 200)
    begin
      ticks(1);
      n++;
    end
    done = (ready_i === 1'b1);
  endtask : wr

  // Bus released before the device may drive it
  task automatic rd(input logic b1, input logic b2, output logic [7:0] d);
    drv_o <= 1'b0;
    bs1_o <= b1;
    bs2_o <= b2;
    oe_n_o <= 1'b0;
    ticks(6);
    d = bus_i;
    oe_n_o <= 1'b1;
    ticks(6);
    drv_o <= 1'b1;
    ticks(1);
  endtask : rd
endmodule : ppnvm_prog_model

// *** ppnvm_port_tb.sv ***
`timescale 1ns/1ps
module ppnvm_port_tb;
  import ppnvm_pkg::*;
  // Arbitrary identity and calibration values
  localparam logic [7:0] ID0 = 8'h3c;
  localparam logic [7:0] ID1 = 8'h61;
  localparam logic [7:0] ID2 = 8'h7e;
  localparam logic [7:0] CAL = 8'h9d;
  logic       clk_sys_i, rst_n_i, strobe, bs1, bs2, wr_n, oe_n, drv, busy, done, oe, rdy;
  logic [1:0] act;
  logic [7:0] pdat, dout, bus, rv;
  int         fail_count, num_checks, cyc, a, i, flo, fhi, lk, pg, ep;
  int         fl[FLASH_WORDS];
  int         ee[EE_BYTES];
  // Undriven bus shows the inverse of the last value
  assign bus = oe ? dout : (drv ? pdat : ~pdat);

  ppnvm_port #(.PROG_CYCLES(20), .ERASE_CYCLES(40), .ID_BYTE0(ID0), .ID_BYTE1(ID1), .ID_BYTE2(ID2),
    .CAL_BYTE(CAL)) u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .load_strobe_i(strobe),
    .action_select_hi_i(act[1]), .action_select_lo_i(act[0]), .byte_select_one_i(bs1),
    .byte_select_two_i(bs2), .write_n_i(wr_n), .output_enable_n_i(oe_n), .data_i(bus),
    .data_o(dout), .data_oe_o(oe), .ready_busy_flag_o(rdy));
  ppnvm_prog_model u_p (.clk_sys_i(clk_sys_i), .ready_i(rdy), .bus_i(bus), .strobe_o(strobe),
    .act_o(act), .bs1_o(bs1), .bs2_o(bs2), .wr_n_o(wr_n), .oe_n_o(oe_n), .drv_o(drv), .dat_o(pdat));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // ********************
  // Checking helpers
  // ********************
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic chk_bit(input logic e, input logic g);
    chk({7'h0, e}, {7'h0, g});
  endtask : chk_bit

  task automatic wr(input logic b1, input logic b2, input logic eb);
    u_p.wr(b1, b2, busy, done);
    chk_bit(eb, busy);
    chk_bit(1'b1, done);
  endtask : wr

  task automatic rd(input logic b1, input logic b2, input int e);
    u_p.rd(b1, b2, rv);
    chk(e[7:0], rv);
    chk_bit(1'b0, oe);
  endtask : rd

  task automatic lo(input int x);
    u_p.pulse(ACT_ADDR, 1'b0, x[7:0]);
  endtask : lo

  task automatic hi(input int x);
    u_p.pulse(ACT_ADDR, 1'b1, {6'h0, x[9:8]});
  endtask : hi

  task automatic erase();
    u_p.cmd(CMD_ERASE_ALL);
    wr(1'b0, 1'b0, 1'b1);
    foreach (fl[k]) fl[k] = 'hffff;
    if (fhi[KEEP_EE_BIT])
      foreach (ee[k]) ee[k] = 'hff;
    lk = 'hff;
  endtask : erase

  task automatic peek(input int fa, input int ea);
    u_p.cmd(CMD_RD_FLASH);
    hi(fa);
    lo(fa);
    rd(1'b0, 1'b0, fl[fa]);
    rd(1'b1, 1'b0, fl[fa] >> 8);
    u_p.cmd(CMD_RD_EEPROM);
    lo(ea);
    rd(1'b0, 1'b0, ee[ea]);
    u_p.cmd(CMD_RD_FUSE);
    rd(1'b0, 1'b0, flo);
    rd(1'b1, 1'b1, fhi);
    rd(1'b1, 1'b0, lk);
  endtask : peek

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ********************
  // Test sequence
  // ********************
  initial
  begin
    rst_n_i = 1'b0;
    {fail_count, num_checks, cyc} = '0;
    {flo, fhi, lk} = {32'hff, 32'hff, 32'hff};
    void'($urandom(38862));
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    erase();
    peek(0, 5);
    $display("test erase done");
    pg = $urandom_range(63);
    u_p.cmd(CMD_WR_FLASH);
    for (i = 0; i < 4; i++)
    begin
      a = pg * 16 + i * 5;
      lo(a);
      fl[a] = $urandom_range(16'hffff);
      u_p.pulse(ACT_DATA, 1'b0, fl[a][7:0]);
      u_p.pulse(ACT_DATA, 1'b1, fl[a][15:8]);
    end
    hi(a);
    wr(1'b0, 1'b0, 1'b1);
    u_p.cmd(CMD_NOP);
    wr(1'b0, 1'b0, 1'b0);
    u_p.cmd(CMD_RD_FLASH);
    for (i = 0; i < 4; i++)
    begin
      a = pg * 16 + i * 5;
      lo(a);
      rd(1'b0, 1'b0, fl[a]);
      rd(1'b1, 1'b0, fl[a] >> 8);
    end
    u_p.pulse(ACT_IDLE, 1'b0, 8'h00);
    rd(1'b0, 1'b0, fl[a]);
    $display("test flash done");
    ep = $urandom_range(31);
    u_p.cmd(CMD_WR_EEPROM);
    for (i = 0; i < 4; i += 3)
    begin
      lo(ep * 4 + i);
      ee[ep * 4 + i] = $urandom_range(255);
      u_p.pulse(ACT_DATA, 1'b0, ee[ep * 4 + i][7:0]);
    end
    wr(1'b0, 1'b0, 1'b1);
    u_p.cmd(CMD_RD_EEPROM);
    for (i = 0; i < 4; i += 3)
    begin
      lo(ep * 4 + i);
      rd(1'b0, 1'b0, ee[ep * 4 + i]);
    end
    $display("test eeprom done");
    u_p.cmd(CMD_WR_FUSE);
    flo = $urandom_range(255);
    u_p.pulse(ACT_DATA, 1'b0, flo[7:0]);
    wr(1'b0, 1'b0, 1'b1);
    fhi = $urandom_range(255) & 'hf7;
    u_p.pulse(ACT_DATA, 1'b0, fhi[7:0]);
    wr(1'b1, 1'b0, 1'b1);
    u_p.cmd(CMD_WR_LOCK);
    lk = 'hfc | $urandom_range(2);
    u_p.pulse(ACT_DATA, 1'b0, lk[7:0]);
    wr(1'b0, 1'b0, 1'b1);
    u_p.pulse(ACT_DATA, 1'b0, 8'hff);
    wr(1'b0, 1'b0, 1'b1);
    peek(a, ep * 4);
    erase();
    peek(a, ep * 4);
    $display("test fuse lock done");
    u_p.cmd(CMD_RD_ID);
    for (i = 0; i < 4; i++)
    begin
      lo(i);
      if (i < 3)
        rd(1'b0, 1'b0, i == 0 ? ID0 : (i == 1 ? ID1 : ID2));
      rd(1'b1, 1'b0, CAL);
    end
    $display("test ident done");
    summarize();
  end
endmodule : ppnvm_port_tb
